// File: logic/apis_pkg.sv
// Package: register map, field layout and reset values of the port-isolation block
package apis_pkg;
   localparam int unsigned NUM_CH = 10;
   localparam logic [11:0] OFF_MGMT = 12'h000;
   localparam logic [11:0] OFF_ISO = 12'h008;
   localparam logic [11:0] OFF_IEN = 12'h00c;
   localparam logic [11:0] OFF_RAW = 12'h010;
   localparam logic [11:0] OFF_MIRQ = 12'h014;
   localparam int unsigned CHSEL_LSB = 0;
   localparam int unsigned CHSEL_W = 4;
   localparam int unsigned GEN_BIT = 4;
   localparam int unsigned DONE_BIT = 5;
   localparam int unsigned START_BIT = 6;
   localparam logic [3:0] CHSEL_MAX = 4'h9;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage : apis_pkg

// File: logic/apis_pin_route.sv
// Pad routing: one analog channel to the converter, digital path isolation
`timescale 1ns/10ps
module apis_pin_route #(
   parameter int unsigned NCH = 10
) (
   input wire logic [3:0] channel_select,      // Selected channel code
   input wire logic global_channel_enable,     // Global analog connect
   input wire logic [NCH-1:0] pin_analog_only_mask, // Isolation mask
   output logic [NCH-1:0] analog_connect,      // Pin to converter input
   output logic [NCH-1:0] digital_enable       // Digital path enable
);
   // Reserved codes match no pin, so nothing connects
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_pin
         assign analog_connect[g] = global_channel_enable &
            (channel_select == 4'(g));
         assign digital_enable[g] = ~pin_analog_only_mask[g];
      end
   endgenerate
endmodule : apis_pin_route

// File: logic/apis_top.sv
// AHB-Lite register bank with port 2 isolation and channel interrupts
// Operation
// - Only one port pin reaches converter
// - Unselected pins stay digital unless masked
// - Mask bit one isolates pin digital path
// - Enabled channel completion raises interrupt
// - Raw flag shows pending channel interrupt
// - Writing zero clears flag and request unless a completion sets that flag in the same cycle
// - Codes zero to nine pick channels
// - Global enable connects or disconnects channels
// - Done clears start unless a write sets start that cycle; start clears done unless done arrives that cycle
`timescale 1ns/10ps
module apis_top (
   input wire logic hclk,                 // Bus clock, 40 MHz
   input wire logic hresetn,              // Async reset, active low
   input wire logic hsel,                 // Slave select
   input wire logic [31:0] haddr,         // Byte address
   input wire logic [1:0] htrans,         // Transfer type
   input wire logic hwrite,               // Write when high
   input wire logic [2:0] hsize,          // Transfer size
   input wire logic hready,               // Bus ready in
   input wire logic [31:0] hwdata,        // Write data
   output logic [31:0] hrdata,            // Read data
   output logic hreadyout,                // Slave ready
   output logic hresp,                    // Response, always OKAY
   input wire logic conv_done,            // Converter finished, pulse
   output logic conv_start,               // Start level to converter
   output logic [3:0] channel_select,     // Channel code to converter
   output logic [9:0] analog_connect,     // Pin to converter input
   output logic [9:0] digital_enable,     // Pad digital path enable
   output logic irq                       // Level interrupt
);
   localparam int unsigned N = apis_pkg::NUM_CH;
   // Checks below run on the bus clock and rest while in reset
   default clocking cb_chk @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ----------------------------------------------------------------
   // Bus address phase capture
   // ----------------------------------------------------------------
   logic wr_q, rd_q;
   logic [11:0] addr_q;
   logic done_q;
   logic [6:0] mgmt_q;
   logic [N-1:0] iso_q, ien_q, raw_q, mirq_q;
   logic [N-1:0] raw_d, mirq_d;
   logic conv_done_q;

   wire take = hsel & hready & (htrans == apis_pkg::HTRANS_NONSEQ |
      htrans == apis_pkg::HTRANS_SEQ);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Register transfer intent for the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         wr_q <= take & hwrite;
         rd_q <= take & ~hwrite;
         addr_q <= {haddr[11:2], 2'h0};
      end
   end

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] off);
      hit = (a == off);
   endfunction : hit

   wire wr_mgmt = wr_q & hit(addr_q, apis_pkg::OFF_MGMT);
   wire wr_iso = wr_q & hit(addr_q, apis_pkg::OFF_ISO);
   wire wr_ien = wr_q & hit(addr_q, apis_pkg::OFF_IEN);
   wire wr_raw = wr_q & hit(addr_q, apis_pkg::OFF_RAW);
   wire rd_mirq = rd_q & hit(addr_q, apis_pkg::OFF_MIRQ);
   wire start_set = wr_mgmt & hwdata[apis_pkg::START_BIT];

   // Converter completion, one-cycle event per done pulse while start is set
   wire done_evt = conv_done & ~conv_done_q & mgmt_q[apis_pkg::START_BIT];
   wire [3:0] cs = mgmt_q[3:0];
   wire cs_ok = cs <= apis_pkg::CHSEL_MAX;
   wire [N-1:0] ch_evt = (done_evt & cs_ok) ?
      N'(1) << cs : '0;
   wire [N-1:0] raw_wzero = wr_raw ? ~hwdata[N-1:0] : '0;

   // Set wins over the clearing write
   assign raw_d = (raw_q & ~raw_wzero) | (ch_evt & ien_q);
   // Masked status: read clears, event set wins
   assign mirq_d = (rd_mirq ? '0 : mirq_q) | (ch_evt & ien_q);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         conv_done_q <= 1'b0;
         mgmt_q <= 7'h00;
         done_q <= 1'b0;
         iso_q <= '0;
         ien_q <= '0;
         raw_q <= '0;
         mirq_q <= '0;
      end else begin
         conv_done_q <= conv_done;
         raw_q <= raw_d;
         mirq_q <= mirq_d;
         if (wr_iso) iso_q <= hwdata[N-1:0];
         if (wr_ien) ien_q <= hwdata[N-1:0];
         if (wr_mgmt) begin
            mgmt_q <= {hwdata[6], 1'b0, hwdata[4:0]};
         end else if (done_evt) begin
            mgmt_q[apis_pkg::START_BIT] <= 1'b0;
         end
         if (done_evt) done_q <= 1'b1;
         else if (start_set) done_q <= 1'b0;
      end
   end

   // Read mux, reserved bits read zero
   logic [31:0] rmux;
   always_comb begin
      rmux = 32'h0000_0000;
      unique case (addr_q)
         apis_pkg::OFF_MGMT: rmux = {25'h0, mgmt_q[6], done_q, mgmt_q[4:0]};
         apis_pkg::OFF_ISO: rmux = {22'h0, iso_q};
         apis_pkg::OFF_IEN: rmux = {22'h0, ien_q};
         apis_pkg::OFF_RAW: rmux = {22'h0, raw_q};
         apis_pkg::OFF_MIRQ: rmux = {22'h0, mirq_q};
         default: rmux = 32'h0000_0000;
      endcase
   end
   assign hrdata = rd_q ? rmux : 32'h0000_0000;

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign conv_start = mgmt_q[apis_pkg::START_BIT];
   assign channel_select = cs;
   assign irq = |(raw_q & ien_q);

   apis_pin_route #(.NCH(N)) u_route (
      .channel_select(cs),
      .global_channel_enable(mgmt_q[apis_pkg::GEN_BIT]),
      .pin_analog_only_mask(iso_q),
      .analog_connect(analog_connect),
      .digital_enable(digital_enable)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Converter completion, one cycle per rising done pulse while start is set
   sequence s_done;
      done_evt;
   endsequence
   // Completion on a legal code whose channel enable is set
   sequence s_done_en;
      s_done ##0 (cs_ok && ien_q[cs]);
   endsequence
   // Completion on a legal code whose channel enable is clear
   sequence s_done_dis;
      s_done ##0 (cs_ok && !ien_q[cs] && !raw_q[cs]);
   endsequence
   // Accepted address phases of a write and of a read
   sequence s_wr_addr;
      take && hwrite;
   endsequence
   sequence s_rd_addr;
      take && !hwrite;
   endsequence
   // Mask write: address phase, then its data phase
   sequence s_iso_xfer;
      s_wr_addr ##0 (haddr[11:0] == apis_pkg::OFF_ISO) ##1 1'b1;
   endsequence
   // Flag read: address phase, then its data phase
   sequence s_raw_rd;
      s_rd_addr ##0 (haddr[11:0] == apis_pkg::OFF_RAW) ##1 1'b1;
   endsequence
   // Data phase of a flag write with no completion beside it
   sequence s_raw_quiet;
      wr_raw && !done_evt;
   endsequence

   // ----------------------------------------------------------------
   // Pad routing checks
   // ----------------------------------------------------------------
   one_pin_a: assert property ($onehot0(analog_connect))
      else $error("two pins routed");
   gen_off_a: assert property (
      !mgmt_q[apis_pkg::GEN_BIT] |-> analog_connect == '0)
      else $error("connect while disabled");
   gen_on_a: assert property (
      mgmt_q[apis_pkg::GEN_BIT] && cs_ok |-> analog_connect[cs])
      else $error("selected channel not connected");
   rsv_code_a: assert property (!cs_ok |-> analog_connect == '0)
      else $error("reserved code connected");
   iso_pin_a: assert property ((digital_enable & iso_q) == '0)
      else $error("isolation leak");
   dig_keep_a: assert property ((~iso_q & ~digital_enable) == '0)
      else $error("digital cut");

   // ----------------------------------------------------------------
   // Bus and register checks
   // ----------------------------------------------------------------
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   wr_phase_a: assert property (s_wr_addr |=> wr_q && !rd_q)
      else $error("write phase lost");
   rd_phase_a: assert property (s_rd_addr |=> rd_q && !wr_q)
      else $error("read phase lost");
   rd_idle_a: assert property (!rd_q |-> hrdata == '0)
      else $error("read data outside data phase");
   rsv_bits_a: assert property (rd_q |-> hrdata[31:N] == '0)
      else $error("reserved bits not zero");
   iso_xfer_a: assert property (
      s_iso_xfer |=> iso_q == $past(hwdata[N-1:0]))
      else $error("mask write lost");
   iso_hold_a: assert property (!wr_iso |=> $stable(iso_q))
      else $error("mask changed without write");
   ien_wr_a: assert property (
      wr_ien |=> ien_q == $past(hwdata[N-1:0]))
      else $error("enable write lost");
   ien_hold_a: assert property (!wr_ien |=> $stable(ien_q))
      else $error("enable changed without write");
   cs_wr_a: assert property (
      wr_mgmt |=> cs == $past(hwdata[3:0]))
      else $error("channel code write lost");
   gen_wr_a: assert property (
      wr_mgmt |=> mgmt_q[apis_pkg::GEN_BIT] ==
      $past(hwdata[apis_pkg::GEN_BIT]))
      else $error("global enable write lost");
   raw_rd_a: assert property (
      s_raw_rd |-> hrdata[N-1:0] == raw_q)
      else $error("flag read wrong");

   // ----------------------------------------------------------------
   // Flag and interrupt checks
   // ----------------------------------------------------------------
   flag_set_a: assert property (s_done_en |=> raw_q[$past(cs)])
      else $error("flag not set");
   no_ien_a: assert property (s_done_dis |=> !raw_q[$past(cs)])
      else $error("flag set while disabled");
   mirq_set_a: assert property (s_done_en |=> mirq_q[$past(cs)])
      else $error("masked status not set");
   raw_rise_a: assert property (
      !done_evt |=> (raw_q & ~$past(raw_q)) == '0)
      else $error("flag rose without completion");
   raw_ien_a: assert property (
      done_evt |=> (raw_q & ~$past(raw_q) & ~$past(ien_q)) == '0)
      else $error("disabled channel flagged");
   no_start_a: assert property (
      conv_done && !conv_start && !wr_raw |=> raw_q == $past(raw_q))
      else $error("completion counted while idle");
   wz_clear_a: assert property (
      s_raw_quiet |=> (raw_q & ~$past(hwdata[N-1:0])) == '0)
      else $error("write zero kept flag");
   w1_keep_a: assert property (
      s_raw_quiet |=> (raw_q & $past(hwdata[N-1:0])) ==
      ($past(raw_q) & $past(hwdata[N-1:0])))
      else $error("write one changed flag");
   wz_irq_a: assert property (
      s_raw_quiet ##0 ((raw_q & ien_q & hwdata[N-1:0]) == '0) |=> !irq)
      else $error("request not withdrawn");
   raw_hold_a: assert property (
      !wr_raw |=> (~raw_q & $past(raw_q)) == '0)
      else $error("flag dropped without write");
   mirq_clr_a: assert property (
      rd_mirq && !done_evt |=> mirq_q == '0)
      else $error("masked status not cleared by read");
   mirq_hold_a: assert property (
      !rd_mirq && !done_evt |=> $stable(mirq_q))
      else $error("masked status changed");
   irq_or_a: assert property (
      irq == ((raw_q & ien_q) != '0)) else $error("irq mismatch");
   // Each pending enabled channel must hold the request up
   for (genvar i = 0; i < N; i++) begin : g_irq_chk
      ch_irq_a: assert property (
         @(posedge hclk) disable iff (!hresetn)
         raw_q[i] && ien_q[i] |-> irq)
         else $error("pending channel without request");
   end

   // ----------------------------------------------------------------
   // Converter handshake checks
   // ----------------------------------------------------------------
   start_clr_a: assert property (
      s_done and !wr_mgmt |=> !conv_start && done_q)
      else $error("start not cleared");
   start_set_a: assert property (start_set |=> conv_start)
      else $error("start not set");
   done_clr_a: assert property (
      start_set && !done_evt |=> !done_q)
      else $error("done not cleared by start");
   done_hold_a: assert property (
      done_q && !start_set |=> done_q)
      else $error("done dropped");
endmodule : apis_top

// File: verif/apis_conv_model.sv
// Behavioural converter core that ends each started conversion
`timescale 1ns/10ps
module apis_conv_model (
   input wire logic hclk,       // Bus clock
   input wire logic hresetn,    // Async reset, active low
   input wire logic conv_start, // Start level from the block
   output logic conv_done       // One-cycle completion pulse
);
   int unsigned wait_q;
   // Random wait while start is high, then one done pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wait_q <= 0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         if (!conv_start || conv_done) begin
            wait_q <= 0;
         end else if (wait_q == 0) begin
            wait_q <= 1 + $urandom_range(0, 6);
         end else if (wait_q == 1) begin
            conv_done <= 1'b1;
            wait_q <= 0;
         end else begin
            wait_q <= wait_q - 1;
         end
      end
   end
endmodule : apis_conv_model

// File: verif/tb_adc_port_isolation_and_irq.sv
// Self-checking bench for the port isolation and interrupt block
`timescale 1ns/10ps
module tb_adc_port_isolation_and_irq;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, m, raw;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, conv_done, conv_start, irq;
   logic [3:0] channel_select;
   logic [9:0] analog_connect, digital_enable, ien;
   int miscompares = 0, checked = 0, cycles = 0;
   always #12.5 hclk = ~hclk;
   apis_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
      .conv_start(conv_start), .channel_select(channel_select),
      .analog_connect(analog_connect), .digital_enable(digital_enable),
      .irq(irq));
   apis_conv_model i_conv (.hclk(hclk), .hresetn(hresetn),
      .conv_start(conv_start), .conv_done(conv_done));
   // Expected converter connection for a management word
   function automatic logic [9:0] conn(input logic g, input logic [3:0] c);
      return (g && c < 4'ha) ? 10'h001 << c : 10'h000;
   endfunction : conn
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One AHB-Lite single transfer; read data lands in rd
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= apis_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic wrap_up();
      if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(44));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk({20'h0, digital_enable, hresp, irq}, 32'hffc);
      for (int a = 8; a <= 32; a += 4) begin
         xfer(a[11:0], 1'b0, 32'h0);
         chk(rd, 32'h0);
      end
      m = 32'hffff_ffff;
      for (int i = 0; i < 4; i++) begin
         xfer(apis_pkg::OFF_ISO, 1'b1, m);
         xfer(apis_pkg::OFF_ISO, 1'b0, 32'h0);
         chk(rd, m & 32'h3ff);
         chk({22'h0, digital_enable}, {22'h0, ~m[9:0]});
         m = $urandom;
      end
      xfer(apis_pkg::OFF_ISO, 1'b1, 32'h0);
      for (int c = 0; c < 32; c++) begin
         xfer(apis_pkg::OFF_MGMT, 1'b1, c);
         @(posedge hclk);
         m = {18'h0, c[3:0], conn(c[4], c[3:0])};
         chk({18'h0, channel_select, analog_connect}, m);
      end
      ien = $urandom;
      ien[1:0] = 2'b01;
      raw = 32'h0;
      xfer(apis_pkg::OFF_IEN, 1'b1, {22'h3f, ien});
      xfer(apis_pkg::OFF_IEN, 1'b0, 32'h0);
      chk(rd, {22'h0, ien});
      for (int ch = 0; ch < 10; ch++) begin
         xfer(apis_pkg::OFF_MGMT, 1'b1, 32'h50 | ch);
         @(posedge hclk);
         for (int k = 0; k < 40 && conv_start !== 1'b0; k++) @(posedge hclk);
         xfer(apis_pkg::OFF_MGMT, 1'b0, 32'h0);
         chk(rd, 32'h30 | ch);
         raw[ch] = ien[ch];
         xfer(apis_pkg::OFF_RAW, 1'b0, 32'h0);
         chk(rd, raw);
         chk(irq, |raw);
      end
      xfer(apis_pkg::OFF_MIRQ, 1'b0, 32'h0);
      chk(rd, raw);
      xfer(apis_pkg::OFF_MIRQ, 1'b0, 32'h0);
      chk(rd, 32'h0);
      xfer(apis_pkg::OFF_IEN, 1'b1, 32'h0);
      @(posedge hclk);
      chk(irq, 1'b0);
      xfer(apis_pkg::OFF_IEN, 1'b1, {22'h0, ien});
      m = $urandom;
      xfer(apis_pkg::OFF_RAW, 1'b1, m);
      raw = raw & m;
      xfer(apis_pkg::OFF_RAW, 1'b0, 32'h0);
      chk(rd, raw);
      chk(irq, |raw);
      xfer(apis_pkg::OFF_RAW, 1'b1, 32'h0);
      @(posedge hclk);
      chk(irq, 1'b0);
      wrap_up();
   end
endmodule : tb_adc_port_isolation_and_irq
